/* pkg/lsc_pkg.sv */
package lsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and the address bit that carries the sync command.
    localparam logic [7:0] LSC_ADDR_COMMAND = 8'h00;
    localparam logic [7:0] LSC_ADDR_RESULT_LOW = 8'h01;
    localparam logic [7:0] LSC_ADDR_RESULT_HIGH = 8'h02;
    localparam int LSC_SYNC_ADDR_BIT = 7;
    localparam logic [7:0] LSC_UNMAPPED_READ = 8'h00;

    // Values after reset.
    localparam logic [7:0] LSC_COMMAND_RESET = 8'h00;
    localparam logic [15:0] LSC_RESULT_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Command register field positions.
    localparam int LSC_BIT_ENABLE = 7;
    localparam int LSC_BIT_CONTINUOUS = 6;
    localparam int LSC_BIT_INFRARED = 5;
    localparam int LSC_TIMING_HI = 4;
    localparam int LSC_TIMING_LO = 2;
    localparam int LSC_RANGE_HI = 1;
    localparam int LSC_RANGE_LO = 0;

    // Timing mode and resolution codes.
    localparam logic [2:0] LSC_TIMING_INT16 = 3'h0;
    localparam logic [2:0] LSC_TIMING_INT12 = 3'h1;
    localparam logic [2:0] LSC_TIMING_INT8 = 3'h2;
    localparam logic [2:0] LSC_TIMING_INT4 = 3'h3;
    localparam logic [2:0] LSC_TIMING_EXT_ADC = 3'h4;
    localparam logic [2:0] LSC_TIMING_EXT_TIMER = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // Integration lengths in oscillator cycles for internal timing.
    localparam logic [16:0] LSC_CYCLES_RES16 = 17'h10000;
    localparam logic [16:0] LSC_CYCLES_RES12 = 17'h01000;
    localparam logic [16:0] LSC_CYCLES_RES8 = 17'h00100;
    localparam logic [16:0] LSC_CYCLES_RES4 = 17'h00010;

    // Converter model: photo current fraction bits and shift per range step.
    localparam int LSC_PHOTO_W = 8;
    localparam int LSC_ACC_W = 24;
    localparam logic [4:0] LSC_PHOTO_FRAC_BITS = 5'h08;
    localparam logic [15:0] LSC_FULL_COUNT = 16'hffff;

    typedef enum logic [1:0] {LSC_IDLE, LSC_INTEGRATE, LSC_HOLD} lsc_osc_state_t;

endpackage

/* src/lsc_sync2.sv */
// Two-stage level synchroniser; the first stage feeds only the second.
module lsc_sync2
    import lsc_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } lsc_sync_state_t;

    lsc_sync_state_t s;
    lsc_sync_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Shift the sampled level through both stages.
    always_comb
    begin
        next_s.stage1 = d;
        next_s.stage2 = s.stage1;
    end

    // Synchronous reset only, so a reset that is itself being synchronised
    // can pass through an instance whose reset port is held low.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign q = s.stage2;

endmodule

/* src/lsc_conversion_control.sv */
//
// Overview of operation
// (R1) Bit 5 selects visible or infrared sensing.
// (R2) Bit 7 enables, zero powers down.
// (R3) Bit 6: one-shot then shutdown, or continuous.
// (R4) Address bit 7 write restarts external integration.
// (R5) Bits 4:2 decode timing mode and resolution.
// (R6) Internal lengths 65536, 4096, 256, 16 cycles.
// (R7) Resolution changes integration period, not width.
// (R8) First sync starts, later syncs complete-and-restart.
// (R9) Timer code returns cycles between last syncs.
// (R10) Host rewrites converter code before reading result.
// (R11) Timer and result share addresses 01, 02.
// (R12) Result bytes read-only, high 02, low 01.
// (R13) Data registers refresh after every conversion.
// (R14) Bits 1:0 choose one of four ranges.
// (R15) Same oscillator; external count follows sync spacing.
// (R16) Host keeps sync spacing below 65535 cycles.
// (R17) Host writes 1xx000xx for 16-bit internal.
// (R18) Reserved timing codes start nothing, keep data.
//
module lsc_conversion_control
    import lsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic osc_clk,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [LSC_PHOTO_W-1:0] photo_visible,
    input wire logic [LSC_PHOTO_W-1:0] photo_infrared,
    output logic ir_select,
    output logic [1:0] full_scale_range,
    output logic integrating
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the register side, clocked by core_clk.
    typedef struct packed {
        logic [7:0] command;
        logic [15:0] adc_hold;
        logic [15:0] timer_hold;
        logic [7:0] rdata;
        logic run;
        logic oneshot_done;
        logic sync_tgl;
        logic ack_tgl;
        logic done_seen;
    } lsc_core_state_t;

    // State of the integrator, clocked by the internal oscillator.
    typedef struct packed {
        lsc_osc_state_t state;
        logic [15:0] counter;
        logic [LSC_ACC_W-1:0] acc;
        logic [15:0] adc_word;
        logic [15:0] timer_word;
        logic done_tgl;
        logic sync_seen;
        logic integrating;
    } lsc_osc_regs_t;

    lsc_core_state_t c;
    lsc_core_state_t next_c;
    lsc_osc_regs_t o;
    lsc_osc_regs_t next_o;

    logic osc_rst;
    logic [8:0] cfg_s;
    logic [1:0] tgl_s;
    logic [2*LSC_PHOTO_W-1:0] photo_s;
    logic done_s;

    ////////////////////////////////////////////////////////////////////////////
    // Crossings. The command word crosses as levels through two flops; the
    // host changes it rarely, and a stray mixed value lasts one oscillator
    // cycle at most, which is the price of not adding a handshake for it.
    lsc_sync2 #(.W(1)) u_rst_sync (
        .clk(osc_clk),
        .rst(1'b0),
        .d(rst),
        .q(osc_rst)
    );

    lsc_sync2 #(.W(9)) u_cfg_sync (
        .clk(osc_clk),
        .rst(osc_rst),
        .d({c.run, c.command}),
        .q(cfg_s)
    );

    lsc_sync2 #(.W(2)) u_tgl_sync (
        .clk(osc_clk),
        .rst(osc_rst),
        .d({c.ack_tgl, c.sync_tgl}),
        .q(tgl_s)
    );

    lsc_sync2 #(.W(2 * LSC_PHOTO_W)) u_photo_sync (
        .clk(osc_clk),
        .rst(osc_rst),
        .d({photo_infrared, photo_visible}),
        .q(photo_s)
    );

    // The result words hold while done_tgl differs from ack, so only the toggle crosses.
    lsc_sync2 #(.W(1)) u_done_sync (
        .clk(core_clk),
        .rst(rst),
        .d(o.done_tgl),
        .q(done_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator-side decode of the synchronised command.
    logic [2:0] o_timing;
    logic o_internal;
    logic o_external;
    logic o_run;
    logic sync_edge;
    logic busy;
    logic [15:0] last_cycle;
    logic [LSC_PHOTO_W-1:0] photo;
    logic [LSC_ACC_W-1:0] acc_sum;
    logic [4:0] range_shift;
    logic [LSC_ACC_W-1:0] scaled;
    logic [15:0] limit;
    logic [15:0] adc_value;

    // Decode timing code, pick the photodiode and scale the running charge.
    always_comb
    begin
        o_timing = cfg_s[LSC_TIMING_HI:LSC_TIMING_LO];
        o_internal = !o_timing[2]; // R5
        o_external = (o_timing == LSC_TIMING_EXT_ADC) || (o_timing == LSC_TIMING_EXT_TIMER); // R5
        o_run = cfg_s[8];
        sync_edge = tgl_s[0] != o.sync_seen;
        busy = o.done_tgl != tgl_s[1];
        case (o_timing[1:0]) // R6 R7
            2'h0: last_cycle = 16'(LSC_CYCLES_RES16 - 17'h00001);
            2'h1: last_cycle = 16'(LSC_CYCLES_RES12 - 17'h00001);
            2'h2: last_cycle = 16'(LSC_CYCLES_RES8 - 17'h00001);
            default: last_cycle = 16'(LSC_CYCLES_RES4 - 17'h00001);
        endcase
        photo = cfg_s[LSC_BIT_INFRARED] ? photo_s[2*LSC_PHOTO_W-1:LSC_PHOTO_W]
                                        : photo_s[LSC_PHOTO_W-1:0]; // R1
        acc_sum = o.acc + {{(LSC_ACC_W - LSC_PHOTO_W){1'b0}}, photo};
        range_shift = LSC_PHOTO_FRAC_BITS
                      + {2'h0, cfg_s[LSC_RANGE_HI:LSC_RANGE_LO], 1'b0}; // R14
        scaled = acc_sum >> range_shift;
        limit = o_internal ? last_cycle : LSC_FULL_COUNT;
        adc_value = (scaled > {8'h00, limit}) ? limit : scaled[15:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Integrator sequence. A finished conversion is offered to the register
    // side only when the previous one was taken; otherwise it is dropped, so
    // the words seen by the core never change while it copies them.
    always_comb
    begin
        next_o = o;
        next_o.sync_seen = tgl_s[0];
        case (o.state)
            LSC_IDLE:
            begin
                next_o.counter = '0;
                next_o.acc = '0;
                if (o_run && o_internal) // R2 R18
                begin
                    next_o.state = LSC_INTEGRATE;
                end
                else if (o_run && o_external && sync_edge) // R8
                begin
                    next_o.state = LSC_INTEGRATE;
                end
            end
            LSC_INTEGRATE:
            begin
                next_o.counter = o.counter + 16'h0001; // R15
                next_o.acc = acc_sum;
                // A power-down or a reserved code abandons the running integration.
                if (!o_run || !(o_internal || o_external)) // R2 R18
                begin
                    next_o.state = LSC_IDLE;
                end
                else if ((o_internal && o.counter == last_cycle)
                         || (o_external && sync_edge)) // R6 R8
                begin
                    if (!busy)
                    begin
                        next_o.adc_word = adc_value;
                        // The capturing edge is itself an integration cycle, so the
                        // count is one more than the counter shows. A count past
                        // 65535 wraps, which the host must avoid by its sync spacing.
                        next_o.timer_word = o.counter + 16'h0001; // R9 R15 R16
                        next_o.done_tgl = !o.done_tgl;
                    end
                    next_o.counter = '0;
                    next_o.acc = '0;
                    if (!cfg_s[LSC_BIT_CONTINUOUS]) // R3
                    begin
                        next_o.state = LSC_HOLD;
                    end
                end
            end
            LSC_HOLD:
            begin
                // A finished one-shot parks here until the register side drops run.
                if (!o_run)
                begin
                    next_o.state = LSC_IDLE;
                end
            end
            default:
            begin
                next_o.state = LSC_IDLE;
            end
        endcase
        next_o.integrating = next_o.state == LSC_INTEGRATE;
    end

    // The integrator resets from the synchronised copy of rst, so its release
    // never lands close to an oscillator edge.
    always_ff @(posedge osc_clk)
    begin
        if (osc_rst)
        begin
            o.state <= LSC_IDLE;
            o.counter <= '0;
            o.acc <= '0;
            o.adc_word <= LSC_RESULT_RESET;
            o.timer_word <= LSC_RESULT_RESET;
            o.done_tgl <= 1'b0;
            o.sync_seen <= 1'b0;
            o.integrating <= 1'b0;
        end
        else
        begin
            o <= next_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register side: command writes, sync commands, result capture, reads.
    logic [2:0] c_timing;
    logic c_reserved;
    logic done_edge;
    logic [15:0] shown;

    always_comb
    begin
        next_c = c;
        c_timing = c.command[LSC_TIMING_HI:LSC_TIMING_LO];
        c_reserved = c_timing[2] && c_timing[1];
        done_edge = done_s != c.done_seen;
        next_c.done_seen = done_s;
        // Host writes; a write to the data addresses changes nothing.
        if (reg_wr)
        begin
            // A sync write is honoured only while an external timing code is loaded.
            if (reg_addr[LSC_SYNC_ADDR_BIT])
            begin
                if (c_timing == LSC_TIMING_EXT_ADC || c_timing == LSC_TIMING_EXT_TIMER) // R4
                begin
                    next_c.sync_tgl = !c.sync_tgl;
                end
            end
            else if (reg_addr == LSC_ADDR_COMMAND) // R12
            begin
                next_c.command = reg_wdata;
                next_c.oneshot_done = 1'b0;
            end
        end
        // Capture comes after the write so a finishing one-shot still wins.
        if (done_edge)
        begin
            next_c.ack_tgl = !c.ack_tgl;
            if (!c_reserved) // R18
            begin
                next_c.adc_hold = o.adc_word; // R13
                next_c.timer_hold = o.timer_word; // R13
            end
            if (!c.command[LSC_BIT_CONTINUOUS]) // R3
            begin
                next_c.oneshot_done = 1'b1;
            end
        end
        next_c.run = next_c.command[LSC_BIT_ENABLE] && !next_c.oneshot_done; // R2 R3
        // Both kinds of data come out of one byte pair, picked by the code.
        shown = (c_timing == LSC_TIMING_EXT_TIMER) ? c.timer_hold : c.adc_hold; // R9 R10 R11
        if (reg_rd)
        begin
            if (reg_addr == LSC_ADDR_COMMAND)
            begin
                next_c.rdata = c.command;
            end
            else if (reg_addr == LSC_ADDR_RESULT_LOW) // R12
            begin
                next_c.rdata = shown[7:0];
            end
            else if (reg_addr == LSC_ADDR_RESULT_HIGH) // R12
            begin
                next_c.rdata = shown[15:8];
            end
            else
            begin
                next_c.rdata = LSC_UNMAPPED_READ;
            end
        end
    end

    // Register side reset; the data registers read zero until a first capture.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            c.command <= LSC_COMMAND_RESET;
            c.adc_hold <= LSC_RESULT_RESET;
            c.timer_hold <= LSC_RESULT_RESET;
            c.rdata <= 8'h00;
            c.run <= 1'b0;
            c.oneshot_done <= 1'b0;
            c.sync_tgl <= 1'b0;
            c.ack_tgl <= 1'b0;
            c.done_seen <= 1'b0;
        end
        else
        begin
            c <= next_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; range and spectrum go straight to the analog front end.
    assign reg_rdata = c.rdata;
    assign ir_select = c.command[LSC_BIT_INFRARED]; // R1
    assign full_scale_range = c.command[LSC_RANGE_HI:LSC_RANGE_LO]; // R14
    assign integrating = o.integrating;

endmodule

/* verification/lsc_light_src.sv */
module lsc_light_src
    import lsc_pkg::*;
(
    input wire logic osc_clk,
    input wire logic [LSC_PHOTO_W-1:0] level_vis,
    input wire logic [LSC_PHOTO_W-1:0] level_ir,
    output logic [LSC_PHOTO_W-1:0] photo_visible,
    output logic [LSC_PHOTO_W-1:0] photo_infrared
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels move only on the oscillator edge, so a new level never lands mid-cycle.
    always_ff @(posedge osc_clk)
    begin
        photo_visible <= level_vis;
        photo_infrared <= level_ir;
    end
endmodule

/* verification/lsc_conversion_control_monitor.sv */
module lsc_conversion_control_monitor
    import lsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic ir_select,
    input wire logic [1:0] full_scale_range,
    input wire logic integrating
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd_m;
    logic [15:0] hi_cnt;
    logic [3:0] off_cnt;
    logic [3:0] rsv_cnt;
    // Mirror of the command and run-length counters; the idle counters saturate.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cmd_m <= LSC_COMMAND_RESET;
            hi_cnt <= 16'h0000;
            off_cnt <= 4'h0;
            rsv_cnt <= 4'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == LSC_ADDR_COMMAND)
                cmd_m <= reg_wdata;
            hi_cnt <= integrating ? hi_cnt + 16'h0001 : 16'h0000;
            off_cnt <= cmd_m[7] ? 4'h0 : (off_cnt == 4'hf ? off_cnt : off_cnt + 4'h1);
            rsv_cnt <= (cmd_m[4:3] != 2'b11) ? 4'h0 : (rsv_cnt == 4'hf ? rsv_cnt : rsv_cnt + 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_unmapped_read_zero: assert property (
        reg_rd && reg_addr > LSC_ADDR_RESULT_HIGH |=> reg_rdata == LSC_UNMAPPED_READ)
        else $error("unmapped read returned nonzero");
    a_command_read_back: assert property (
        reg_rd && !reg_wr && reg_addr == LSC_ADDR_COMMAND |=> reg_rdata == $past(cmd_m))
        else $error("command read back differs");
    a_spectrum_follows: assert property (
        reg_wr && reg_addr == LSC_ADDR_COMMAND |=> ir_select == $past(reg_wdata[5]))
        else $error("spectrum select does not follow write");
    a_range_follows: assert property (
        full_scale_range == cmd_m[1:0])
        else $error("range output differs from command");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_off_stays_idle: assert property (
        off_cnt >= 4'hc |-> !integrating)
        else $error("integration while powered down");
    a_reserved_no_start: assert property (
        rsv_cnt >= 4'hc |-> !integrating)
        else $error("integration under reserved code");
    a_res4_length: assert property (
        $fell(integrating) && !cmd_m[6] && cmd_m[4:2] == 3'h3 |-> hi_cnt inside {[19:23]})
        else $error("4-bit integration length wrong");
    a_res8_length: assert property (
        $fell(integrating) && !cmd_m[6] && cmd_m[4:2] == 3'h2 |-> hi_cnt inside {[325:331]})
        else $error("8-bit integration length wrong");
    c_one_shot_done: cover property ($fell(integrating) && !cmd_m[6]);
    c_external_run: cover property ($rose(integrating) && cmd_m[4]);
    c_reserved_held: cover property (rsv_cnt == 4'hf);
endmodule

bind lsc_conversion_control lsc_conversion_control_monitor lsc_conversion_control_monitor_i (
    .core_clk(core_clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .ir_select(ir_select),
    .full_scale_range(full_scale_range),
    .integrating(integrating)
);

/* verification/lsc_conversion_control_tb.sv */
module lsc_conversion_control_tb
    import lsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, osc_clk, rst, reg_wr, reg_rd, ir_select, integrating;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lvl_vis, lvl_ir;
    logic [LSC_PHOTO_W-1:0] photo_visible, photo_infrared;
    logic [1:0] full_scale_range;
    logic [15:0] w, kept;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int spent;
    lsc_conversion_control lsc_conversion_control_i (.core_clk(core_clk), .rst(rst),
        .osc_clk(osc_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .photo_visible(photo_visible),
        .photo_infrared(photo_infrared), .ir_select(ir_select),
        .full_scale_range(full_scale_range), .integrating(integrating));
    lsc_light_src lsc_light_src_i (.osc_clk(osc_clk), .level_vis(lvl_vis), .level_ir(lvl_ir),
        .photo_visible(photo_visible), .photo_infrared(photo_infrared));
    ////////////////////////////////////////////////////////////////////////////
    // The oscillator starts 7 ns late with a 64 ns period, so its edges drift against the 50 ns core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        osc_clk = 1'b0;
        #7;
        forever #32 osc_clk = ~osc_clk;
    end
    // A hang costs a mismatch and still reaches the report.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #2;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #2;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #2;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #2;
        reg_rd = 1'b0;
        @(posedge core_clk);
        #2;
        d = reg_rdata;
    endtask
    task automatic rd16(output logic [15:0] v);
        rd(LSC_ADDR_RESULT_LOW, v[7:0]);
        rd(LSC_ADDR_RESULT_HIGH, v[15:8]);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_near(input string what, input int exp, input int tol, input logic [15:0] got);
        checks++;
        if (^got === 1'bx || int'(got) > exp + tol || int'(got) + tol < exp)
        begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Bounded wait for the integrating flag; n returns the cycles spent.
    task automatic wait_integ(input logic v, input int lim, output int n);
        n = 0;
        while (integrating !== v && n < lim)
        begin
            @(posedge core_clk);
            #2;
            n++;
        end
        chk("integrating", {15'h0, v}, {15'h0, integrating});
    endtask
    function automatic int exp_data(input int n, input int lvl, input int r);
        int s;
        s = (lvl << n) >> (8 + 2 * r);
        return (s > (1 << n) - 1) ? (1 << n) - 1 : s;
    endfunction
    task automatic one_shot(input logic [7:0] cmd, input int osc_cycles, input int exp);
        int n;
        wr(LSC_ADDR_COMMAND, cmd);
        wait_integ(1'b1, 40, n);
        wait_integ(1'b0, 6000, n);
        chk_near("period", osc_cycles * 64 / 50, 3, 16'(n));
        repeat (10) @(posedge core_clk);
        rd16(w);
        chk("result", 16'(exp), w);
        repeat (20) @(posedge core_clk);
        chk("idle after one-shot", 16'h0, {15'h0, integrating});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
        lvl_vis = 8'hff;
        lvl_ir = 8'h80;
        repeat (2) @(posedge core_clk);
        #2;
        rst = 1'b0;
        for (int a = 0; a < 4; a++)
        begin
            rd(8'(a), w[7:0]);
            chk("reset read", 16'h0, {8'h0, w[7:0]});
        end
        $display("test reset done");
        wr(LSC_ADDR_COMMAND, 8'h23);
        rd(LSC_ADDR_COMMAND, w[7:0]);
        chk("command", 16'h23, {8'h0, w[7:0]});
        chk("fields", 16'h7, {13'h0, ir_select, full_scale_range});
        wr(LSC_ADDR_RESULT_LOW, 8'hff);
        wr(LSC_ADDR_RESULT_HIGH, 8'hff);
        rd16(w);
        chk("data after write", 16'h0, w);
        chk("disabled idle", 16'h0, {15'h0, integrating});
        $display("test fields done");
        for (int c = 1; c < 4; c++)
            one_shot(8'h80 | 8'(c << 2), 1 << (16 - 4 * c), exp_data(16 - 4 * c, 255, 0));
        for (int r = 0; r < 4; r++)
        begin
            one_shot(8'h88 | 8'(r), 256, exp_data(8, 255, r));
            chk("range", 16'(r), {14'h0, full_scale_range});
        end
        one_shot(8'ha8, 256, exp_data(8, 128, 0));
        wr(LSC_ADDR_COMMAND, 8'h80);
        wait_integ(1'b1, 40, spent);
        repeat (6000) @(posedge core_clk);
        chk("16-bit still running", 16'h1, {15'h0, integrating});
        wr(LSC_ADDR_COMMAND, 8'h00);
        wait_integ(1'b0, 20, spent);
        $display("test one-shot done");
        wr(LSC_ADDR_COMMAND, 8'hc8);
        repeat (700) @(posedge core_clk);
        chk("continuous run", 16'h1, {15'h0, integrating});
        rd16(w);
        chk("continuous", 16'(exp_data(8, 255, 0)), w);
        lvl_vis = 8'h80;
        repeat (1000) @(posedge core_clk);
        rd16(w);
        chk("refresh", 16'(exp_data(8, 128, 0)), w);
        wr(LSC_ADDR_COMMAND, 8'h48);
        repeat (20) @(posedge core_clk);
        chk("power down", 16'h0, {15'h0, integrating});
        $display("test continuous done");
        lvl_vis = 8'hff;
        wr(LSC_ADDR_COMMAND, 8'hd4);
        repeat (20) @(posedge core_clk);
        chk("no sync yet", 16'h0, {15'h0, integrating});
        wr(8'h80, 8'h00);
        repeat (200) @(posedge core_clk);
        wr(8'h80, 8'h00);
        repeat (30) @(posedge core_clk);
        chk("external run", 16'h1, {15'h0, integrating});
        rd16(w);
        chk_near("timer", 158, 3, w);
        wr(LSC_ADDR_COMMAND, 8'hd0);
        rd16(kept);
        chk_near("external data", 157, 4, kept);
        $display("test external done");
        wr(LSC_ADDR_COMMAND, 8'hd8);
        wr(8'h80, 8'h00);
        repeat (20) @(posedge core_clk);
        chk("reserved idle", 16'h0, {15'h0, integrating});
        rd16(w);
        chk("reserved kept", kept, w);
        $display("test reserved done");
        wrap_up();
    end
endmodule
